// >>> hw/sqad_top.sv
// squib arming and deploy channel logic with its two serial ports
// Contract
// RL1: set success flag after completed firing
// RL2: switches off except during valid firing
// RL3: two pulse-stretch timers per channel, arming and deploy
// RL4: arming uses separate 8-bit serial port
// RL5: arming select release latches bits, starts timers
// RL6: fire on permit plus cross-source coincidence
// RL7: firing runs full duration, only reset stops
// RL8: deploy-enable starts timer at select end
// RL9: repeated deploy-enable restarts full period
// RL10: deploy-disable stops only deploy timer
// RL11: arming-enable starts timer at select end
// RL12: repeated arming-enable restarts full period
// RL13: arming-disable stops only arming timer
// RL14: while firing, filter main-port message modes
// RL15: arming commands ignored while any firing
// RL16: permit high allows switching, no abort
// RL17: permit low keeps switches off
// RL18: permit low blocks deploy timer start
// RL19: report previous deploy-command bits always
// RL20: arming starts timer regardless of permit
// RL21: permit changes never affect running timers
// RL22: deglitch the permit input
// RL23: periods are clock-cycle parameters
// RL24: separate arming and deploy timer state
`timescale 1ns/10ps
module sqad_top #(
  parameter logic [16:0] STRETCH_CYCLES = 17'(sqad_pkg::STRETCH_CYCLES_DEF),
  parameter logic [16:0] FIRE_CYCLES = 17'(sqad_pkg::FIRE_CYCLES_DEF),
  parameter logic [16:0] GLITCH_CYCLES = 17'(sqad_pkg::GLITCH_CYCLES_DEF)
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic arm_sclk,
  input wire logic arm_mosi,
  input wire logic arm_cs,
  output logic arm_miso_o,
  output logic arm_miso_oe,
  input wire logic main_sclk,
  input wire logic main_mosi,
  input wire logic main_cs,
  output logic main_miso_o,
  output logic main_miso_oe,
  input wire logic fire_permit_input,
  output logic permit_filtered,
  output logic [3:0] high_side_switch,
  output logic [3:0] low_side_switch,
  output logic [3:0] firing_active,
  output logic [3:0] fire_success,
  output logic [3:0] deploy_cmd_status,
  output logic [3:0] arm_timer_running,
  output logic [3:0] deploy_timer_running
);

  // ***************************************************************
  // serial ports
  // ***************************************************************
  sqad_spi_if #(.W(sqad_pkg::ARM_W)) arm_if ();
  sqad_spi_if #(.W(sqad_pkg::MAIN_W)) main_if ();

  sqad_spi_shift #(.W(sqad_pkg::ARM_W), .EXACT(1'b0)) u_arm_shift ( // see RL4
    .mclk(mclk),
    .resetn(resetn),
    .sclk_pin(arm_sclk),
    .mosi_pin(arm_mosi),
    .cs_pin(arm_cs),
    .bus(arm_if.shifter)
  );

  sqad_spi_shift #(.W(sqad_pkg::MAIN_W), .EXACT(1'b1)) u_main_shift (
    .mclk(mclk),
    .resetn(resetn),
    .sclk_pin(main_sclk),
    .mosi_pin(main_mosi),
    .cs_pin(main_cs),
    .bus(main_if.shifter)
  );

  // ***************************************************************
  // permit input synchroniser and deglitch
  // ***************************************************************
  logic p1_r;
  logic p2_r;
  logic p3_r;
  logic permit_r;
  logic [16:0] gcnt_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      p1_r <= 1'b0;
      p2_r <= 1'b0;
      p3_r <= 1'b0;
    end else begin
      p1_r <= fire_permit_input;
      p2_r <= p1_r;
      p3_r <= p2_r;
    end
  end

  // a new level must hold for the full deglitch time
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      permit_r <= 1'b0;
      gcnt_r <= sqad_pkg::TIMER_RST;
    end else if ((p2_r == p3_r) && (p3_r != permit_r)) begin
      if (gcnt_r >= GLITCH_CYCLES - 17'h00001) begin
        permit_r <= p3_r; // see RL22
        gcnt_r <= sqad_pkg::TIMER_RST;
      end else begin
        gcnt_r <= gcnt_r + 17'h00001;
      end
    end else begin
      gcnt_r <= sqad_pkg::TIMER_RST; // see RL22
    end
  end

  // ***************************************************************
  // channel state
  // ***************************************************************
  logic [sqad_pkg::TW-1:0] arm_cnt_r [sqad_pkg::NCH];
  logic [sqad_pkg::TW-1:0] dep_cnt_r [sqad_pkg::NCH];
  logic [sqad_pkg::TW-1:0] fire_cnt_r [sqad_pkg::NCH];
  sqad_pkg::sqad_ch_state_type ch_state_r [sqad_pkg::NCH];
  logic [3:0] arm_run;
  logic [3:0] dep_run;
  logic [3:0] firing;
  logic [3:0] fire_end;
  logic any_firing;

  always_comb begin
    for (int c = 0; c < sqad_pkg::NCH; c++) begin
      arm_run[c] = (arm_cnt_r[c] != sqad_pkg::TIMER_RST);
      dep_run[c] = (dep_cnt_r[c] != sqad_pkg::TIMER_RST);
      firing[c] = (ch_state_r[c] == sqad_pkg::CH_FIRE);
      fire_end[c] = firing[c] && (fire_cnt_r[c] == 17'h00001);
    end
  end

  assign any_firing = |firing;

  // ***************************************************************
  // command decode
  // ***************************************************************
  sqad_pkg::sqad_mode_type mode;
  logic [3:0] arm_bits;
  logic [3:0] dep_bits;
  logic arm_ok;
  logic main_ok;
  logic cmd_ok;
  logic mon_ok;
  logic [3:0] arm_on;
  logic [3:0] arm_off;
  logic [3:0] dep_on;
  logic [3:0] dep_off;
  logic [3:0] fire_start;

  assign mode = sqad_pkg::sqad_mode_type'(main_if.rx_word[sqad_pkg::MODE_MSB:sqad_pkg::MODE_LSB]);
  assign arm_bits = arm_if.rx_word[sqad_pkg::ARM_BITS_LSB+:4];
  assign dep_bits = main_if.rx_word[sqad_pkg::CMD_DEPLOY_LSB+:4];
  assign arm_ok = arm_if.frame_done && arm_if.count_ok && !any_firing; // see RL15
  assign main_ok = main_if.frame_done && main_if.count_ok;
  assign cmd_ok = main_ok && (mode == sqad_pkg::MODE_CMD);
  assign mon_ok = main_ok && (mode == sqad_pkg::MODE_MON);

  always_comb begin
    for (int c = 0; c < sqad_pkg::NCH; c++) begin
      arm_on[c] = arm_ok && arm_bits[c]; // see RL5 // see RL20
      arm_off[c] = arm_ok && !arm_bits[c];
      dep_on[c] = cmd_ok && dep_bits[c] && permit_r && !firing[c]; // see RL18 // see RL14
      dep_off[c] = cmd_ok && !dep_bits[c] && !firing[c];
      fire_start[c] = permit_r && !firing[c] && ((dep_on[c] && arm_run[c]) || (arm_on[c] && dep_run[c])); // see RL6
    end
  end

  // ***************************************************************
  // pulse-stretch timers, one pair per channel
  // ***************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        arm_cnt_r[c] <= sqad_pkg::TIMER_RST;
      end
    end else begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        if (arm_on[c]) begin
          arm_cnt_r[c] <= STRETCH_CYCLES; // see RL3 // see RL11 // see RL12 // see RL23
        end else if (arm_off[c]) begin
          arm_cnt_r[c] <= sqad_pkg::TIMER_RST; // see RL13
        end else begin
          arm_cnt_r[c] <= sqad_pkg::tick(arm_cnt_r[c]); // see RL21 // see RL24
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        dep_cnt_r[c] <= sqad_pkg::TIMER_RST;
      end
    end else begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        if (dep_on[c]) begin
          dep_cnt_r[c] <= STRETCH_CYCLES; // see RL8 // see RL9
        end else if (dep_off[c]) begin
          dep_cnt_r[c] <= sqad_pkg::TIMER_RST; // see RL10
        end else begin
          dep_cnt_r[c] <= sqad_pkg::tick(dep_cnt_r[c]); // see RL21 // see RL24
        end
      end
    end
  end

  // ***************************************************************
  // firing sequencer and drive switches
  // ***************************************************************
  logic [3:0] hs_r;
  logic [3:0] ls_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        ch_state_r[c] <= sqad_pkg::CH_IDLE;
        fire_cnt_r[c] <= sqad_pkg::TIMER_RST;
      end
      hs_r <= sqad_pkg::CH_RST;
      ls_r <= sqad_pkg::CH_RST;
    end else begin
      for (int c = 0; c < sqad_pkg::NCH; c++) begin
        case (ch_state_r[c])
          sqad_pkg::CH_IDLE: begin
            hs_r[c] <= 1'b0; // see RL2 // see RL17
            ls_r[c] <= 1'b0;
            if (fire_start[c]) begin
              ch_state_r[c] <= sqad_pkg::CH_FIRE;
              fire_cnt_r[c] <= FIRE_CYCLES; // see RL23
              hs_r[c] <= 1'b1; // see RL16
              ls_r[c] <= 1'b1;
            end
          end
          sqad_pkg::CH_FIRE: begin
            if (fire_end[c]) begin
              ch_state_r[c] <= sqad_pkg::CH_IDLE;
              fire_cnt_r[c] <= sqad_pkg::TIMER_RST;
              hs_r[c] <= 1'b0;
              ls_r[c] <= 1'b0;
            end else begin
              fire_cnt_r[c] <= fire_cnt_r[c] - 17'h00001; // see RL7
            end
          end
          default: begin
            ch_state_r[c] <= sqad_pkg::CH_IDLE;
            hs_r[c] <= 1'b0;
            ls_r[c] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // success flags, cleared by a monitor read, set wins
  // ***************************************************************
  logic [sqad_pkg::MAIN_W-1:0] main_tx_r;
  logic [3:0] success_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      success_r <= sqad_pkg::CH_RST;
    end else begin
      success_r <= (success_r & ~(mon_ok ? main_tx_r[sqad_pkg::RSP_SUCCESS_LSB+:4] : 4'h0)) | fire_end; // see RL1
    end
  end

  // ***************************************************************
  // deploy command echo
  // ***************************************************************
  logic [3:0] dep_status_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dep_status_r <= sqad_pkg::CH_RST;
    end else if (cmd_ok) begin
      dep_status_r <= dep_bits; // see RL19
    end
  end

  // ***************************************************************
  // responses for the next frames
  // ***************************************************************
  logic [sqad_pkg::MAIN_W-1:0] status_word;

  always_comb begin
    status_word = sqad_pkg::MAIN_RSP_RST;
    status_word[sqad_pkg::MODE_MSB:sqad_pkg::MODE_LSB] = mode;
    status_word[sqad_pkg::RSP_FIRING_LSB+:4] = firing;
    status_word[sqad_pkg::RSP_SUCCESS_LSB+:4] = success_r;
    status_word[sqad_pkg::RSP_CMD_LSB+:4] = (mode == sqad_pkg::MODE_CMD) ? dep_bits : dep_status_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      main_tx_r <= sqad_pkg::MAIN_RSP_RST;
    end else if (main_if.frame_done) begin
      if (!main_if.count_ok) begin
        main_tx_r <= sqad_pkg::FAULT_RSP;
      end else if (any_firing && ((mode == sqad_pkg::MODE_REG) || (mode == sqad_pkg::MODE_DIAG))) begin
        main_tx_r <= sqad_pkg::FAULT_RSP; // see RL14
      end else begin
        main_tx_r <= status_word;
      end
    end
  end

  assign main_if.tx_word = main_tx_r;
  assign arm_if.tx_word = {arm_run, dep_run};

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arm_miso_o <= 1'b0;
      arm_miso_oe <= 1'b0;
      main_miso_o <= 1'b0;
      main_miso_oe <= 1'b0;
    end else begin
      arm_miso_o <= arm_if.miso;
      arm_miso_oe <= arm_if.frame_active;
      main_miso_o <= main_if.miso;
      main_miso_oe <= main_if.frame_active;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      permit_filtered <= 1'b0;
      firing_active <= sqad_pkg::CH_RST;
      arm_timer_running <= sqad_pkg::CH_RST;
      deploy_timer_running <= sqad_pkg::CH_RST;
    end else begin
      permit_filtered <= permit_r;
      firing_active <= firing;
      arm_timer_running <= arm_run;
      deploy_timer_running <= dep_run;
    end
  end

  assign high_side_switch = hs_r;
  assign low_side_switch = ls_r;
  assign fire_success = success_r;
  assign deploy_cmd_status = dep_status_r;

endmodule // sqad_top

// >>> pkg/sqad_pkg.sv
// shared constants, types and helpers of the squib arming and deploy logic
package sqad_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NCH = 4;
  localparam int ARM_W = 8;
  localparam int MAIN_W = 16;
  localparam int TW = 17;
  localparam int BCW = 8;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int FIRE_TIME_NS = 2000000;
  localparam int FIRE_CYCLES_DEF = (FIRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_CYCLES_DEF = 10000;
  localparam int GLITCH_CYCLES_DEF = 50;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;
  localparam int FAULT_BIT = 13;
  localparam int RSP_FIRING_LSB = 8;
  localparam int RSP_SUCCESS_LSB = 4;
  localparam int RSP_CMD_LSB = 0;
  localparam int CMD_DEPLOY_LSB = 0;
  localparam int ARM_BITS_LSB = 0;
  localparam int ARM_RSP_ARM_LSB = 4;
  localparam int ARM_RSP_DEP_LSB = 0;
  localparam logic [MAIN_W-1:0] MAIN_RSP_RST = 16'h0000;
  localparam logic [MAIN_W-1:0] FAULT_RSP = 16'hE000;
  localparam logic [TW-1:0] TIMER_RST = 17'h00000;
  localparam logic [NCH-1:0] CH_RST = 4'h0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_REG = 2'b00,
    MODE_CMD = 2'b01,
    MODE_DIAG = 2'b10,
    MODE_MON = 2'b11
  } sqad_mode_type;

  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_FIRE = 1'b1
  } sqad_ch_state_type;

  // count down to zero and stay there
  function automatic logic [TW-1:0] tick(input logic [TW-1:0] cnt);
    tick = (cnt != TIMER_RST) ? cnt - 17'h00001 : TIMER_RST;
  endfunction

endpackage

// >>> pkg/sqad_spi_if.sv
// link between a serial shifter and the channel logic
`timescale 1ns/10ps
interface sqad_spi_if #(parameter int W = 8);
  logic frame_done;
  logic count_ok;
  logic frame_active;
  logic miso;
  logic [W-1:0] rx_word;
  logic [W-1:0] tx_word;

  modport shifter(output frame_done, count_ok, frame_active, miso, rx_word, input tx_word);
  modport user(input frame_done, count_ok, frame_active, miso, rx_word, output tx_word);
endinterface

// >>> hw/sqad_spi_shift.sv
// synchronised serial shifter, one frame per chip select
`timescale 1ns/10ps
module sqad_spi_shift #(
  parameter int W = 8,
  parameter bit EXACT = 1'b0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic cs_pin,
  sqad_spi_if.shifter bus
);

  // ***************************************************************
  // pin synchronisers: bit0 clock, bit1 data, bit2 select
  // ***************************************************************
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;
  logic [2:0] stable;
  logic [2:0] rise;
  logic [2:0] fall;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      filt_r <= 3'h0;
    end else begin
      s1_r <= {cs_pin, mosi_pin, sclk_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 3; i++) begin
        if (stable[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign stable = ~(s2_r ^ s3_r);
  assign rise = stable & s3_r & ~filt_r;
  assign fall = stable & ~s3_r & filt_r;

  // ***************************************************************
  // shift register and bit count
  // ***************************************************************
  logic [W-1:0] sr_r;
  logic [W-1:0] rx_r;
  logic [sqad_pkg::BCW-1:0] cnt_r;
  logic hold_r;
  logic active_r;
  logic done_r;
  logic ok_r;
  logic cnt_ok;

  assign cnt_ok = EXACT ? (cnt_r == 8'(W)) : ((cnt_r != 8'h00) && (cnt_r % 8'(W) == 8'h00));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sr_r <= '0;
      rx_r <= '0;
      cnt_r <= 8'h00;
      hold_r <= 1'b0;
      active_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (rise[2]) begin
        sr_r <= bus.tx_word;
        cnt_r <= 8'h00;
        active_r <= 1'b1;
      end else if (fall[2]) begin
        active_r <= 1'b0;
        done_r <= active_r;
        ok_r <= cnt_ok;
        rx_r <= sr_r;
      end else if (active_r) begin
        if (rise[0]) begin
          hold_r <= s3_r[1];
          if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        if (fall[0]) begin
          sr_r <= {sr_r[W-2:0], hold_r};
        end
      end
    end
  end

  assign bus.frame_done = done_r;
  assign bus.count_ok = ok_r;
  assign bus.frame_active = active_r;
  assign bus.rx_word = rx_r;
  assign bus.miso = sr_r[W-1];

endmodule // sqad_spi_shift

// >>> dv/sqad_host.sv
// host serial master model for the arming and main ports
`timescale 1ns/10ps
module sqad_host (
  input wire logic mclk,
  output logic arm_sclk,
  output logic arm_mosi,
  output logic arm_cs,
  input wire logic arm_miso,
  output logic main_sclk,
  output logic main_mosi,
  output logic main_cs,
  input wire logic main_miso
);
  logic [1:0] cs_r = 2'h0;
  logic [1:0] sclk_r = 2'h0;
  logic [1:0] mosi_r = 2'h0;
  assign arm_cs = cs_r[0];
  assign arm_sclk = sclk_r[0];
  assign arm_mosi = mosi_r[0];
  assign main_cs = cs_r[1];
  assign main_sclk = sclk_r[1];
  assign main_mosi = mosi_r[1];

  // one frame, msb first, clock low outside frames
  task automatic xfer(input int p, input int n, input logic [15:0] tx, output logic [15:0] rx);
    logic [1:0] so;
    rx = 16'h0000;
    cs_r[p] <= 1'h1;
    repeat (8) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      mosi_r[p] <= tx[i];
      repeat (4) @(posedge mclk);
      sclk_r[p] <= 1'h1;
      repeat (4) @(posedge mclk);
      so = {main_miso, arm_miso};
      rx = {rx[14:0], so[p]};
      sclk_r[p] <= 1'h0;
    end
    repeat (4) @(posedge mclk);
    cs_r[p] <= 1'h0;
    repeat (8) @(posedge mclk);
  endtask

  // arming byte on its own port
  task automatic send_arm(input logic [7:0] b, output logic [7:0] r);
    logic [15:0] w;
    xfer(0, 8, {8'h00, b}, w);
    r = w[7:0];
  endtask

  task automatic send_main(input logic [15:0] c, output logic [15:0] r);
    xfer(1, 16, c, r);
  endtask
endmodule  // sqad_host

// >>> dv/sqad_top_assertions.sv
// port checks of the squib channel logic, bound to its top
`timescale 1ns/10ps
module sqad_top_assertions #(
  parameter logic [16:0] FIRE_CYCLES = 17'h186A0,
  parameter logic [16:0] GLITCH_CYCLES = 17'h00032
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic arm_cs,
  input wire logic arm_miso_oe,
  input wire logic fire_permit_input,
  input wire logic permit_filtered,
  input wire logic [3:0] high_side_switch,
  input wire logic [3:0] low_side_switch,
  input wire logic [3:0] firing_active,
  input wire logic [3:0] fire_success,
  input wire logic [3:0] arm_timer_running,
  input wire logic [3:0] deploy_timer_running
);
  // ****
  // helper state
  // ****
  logic [3:0] hs_q_r;
  logic [3:0] run_q_r;
  logic [3:0] rise_w;
  logic [3:0] fall_w;
  logic [16:0] on_cnt_r;
  logic [16:0] stab_r;
  logic perm_q_r;
  assign rise_w = high_side_switch & ~hs_q_r;
  assign fall_w = hs_q_r & ~high_side_switch;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hs_q_r <= 4'h0;
      run_q_r <= 4'h0;
    end else begin
      hs_q_r <= high_side_switch;
      run_q_r <= arm_timer_running | deploy_timer_running;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      on_cnt_r <= 17'h00000;
    end else begin
      on_cnt_r <= high_side_switch[0] ? on_cnt_r + 17'h00001 : 17'h00000;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      perm_q_r <= 1'h0;
      stab_r <= 17'h00000;
    end else begin
      perm_q_r <= fire_permit_input;
      stab_r <= (fire_permit_input != perm_q_r) ? 17'h00000 : (stab_r < GLITCH_CYCLES) ? stab_r + 17'h00001 : stab_r;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_fire_end;
    $fell(high_side_switch[0]);
  endsequence
  sequence s_arm_close;
    $fell(arm_cs);
  endsequence
  AST_SWITCH_PAIR: assert property (high_side_switch == low_side_switch)
    else $error("switch sides differ");
  AST_FIRE_PERMIT: assert property ((rise_w != 4'h0) |-> permit_filtered || $past(permit_filtered))
    else $error("switch on without permit");
  AST_FIRE_TIMER: assert property ((rise_w != 4'h0) |-> ((rise_w & ~(run_q_r | $past(run_q_r))) == 4'h0))
    else $error("switch on without running timer");
  AST_FIRE_LEN: assert property (s_fire_end |-> on_cnt_r == FIRE_CYCLES)
    else $error("firing length wrong");
  AST_SUCCESS_END: assert property ((fall_w != 4'h0) |-> ((fall_w & ~fire_success) == 4'h0))
    else $error("success not set at firing end");
  AST_SUCCESS_CAUSE: assert property ((fire_success & ~$past(fire_success) & ~fall_w) == 4'h0)
    else $error("success set without firing end");
  AST_FIRING_TRACK: assert property (firing_active == $past(high_side_switch))
    else $error("firing status off track");
  AST_DEP_PERMIT: assert property (|(deploy_timer_running & ~$past(deploy_timer_running))
    |-> $past(permit_filtered))
    else $error("deploy timer started without permit");
  AST_ARM_IGNORED: assert property (|(arm_timer_running & ~$past(arm_timer_running))
    |-> !(|$past(high_side_switch, 2)))
    else $error("arming accepted during firing");
  AST_PERMIT_GLITCH: assert property ($changed(permit_filtered) |-> stab_r >= GLITCH_CYCLES)
    else $error("permit followed a short pulse");
  AST_ARM_OE: assert property (s_arm_close |-> ##[1:6] !arm_miso_oe)
    else $error("arming output not released");
endmodule  // sqad_top_assertions

bind sqad_top sqad_top_assertions #(.FIRE_CYCLES(FIRE_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)) u_chk (
  .mclk(mclk),
  .resetn(resetn),
  .arm_cs(arm_cs),
  .arm_miso_oe(arm_miso_oe),
  .fire_permit_input(fire_permit_input),
  .permit_filtered(permit_filtered),
  .high_side_switch(high_side_switch),
  .low_side_switch(low_side_switch),
  .firing_active(firing_active),
  .fire_success(fire_success),
  .arm_timer_running(arm_timer_running),
  .deploy_timer_running(deploy_timer_running)
);

// >>> dv/sqad_top_test.sv
// self-checking bench for the squib channel logic
`timescale 1ns/10ps
module sqad_top_test;
  localparam logic [16:0] STRETCH = 17'h00320;
  localparam logic [16:0] FIRE = 17'h00258;
  typedef struct packed {logic perm; logic ord; logic [7:0] a; logic [15:0] m; logic [3:0] f;} sqad_row_type;
  sqad_row_type rows [5] = '{'{1'h1, 1'h0, 8'h01, 16'h4001, 4'h1}, '{1'h1, 1'h0, 8'h06, 16'h4002, 4'h2},
    '{1'h0, 1'h0, 8'h08, 16'h4008, 4'h0}, '{1'h1, 1'h0, 8'h00, 16'h4004, 4'h0},
    '{1'h1, 1'h1, 8'h08, 16'h4008, 4'h8}};
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic permit = 1'h0;
  wire arm_sclk, arm_mosi, arm_cs, main_sclk, main_mosi, main_cs;
  logic arm_miso_o, arm_miso_oe, main_miso_o, main_miso_oe, permit_filtered;
  logic [3:0] hs, ls, firing, success, dep_status, arm_run, dep_run;
  logic [7:0] ar;
  logic [15:0] mr;
  int failures = 0;
  int n_tests = 0;
  // undriven output line shows a moving pattern
  wire arm_miso = arm_miso_oe ? arm_miso_o : mclk;
  wire main_miso = main_miso_oe ? main_miso_o : mclk;

  initial begin
    forever #10 mclk = ~mclk;
  end

  sqad_top #(.STRETCH_CYCLES(STRETCH), .FIRE_CYCLES(FIRE), .GLITCH_CYCLES(17'h00004)) u_dut (
    .mclk(mclk),
    .resetn(resetn),
    .arm_sclk(arm_sclk),
    .arm_mosi(arm_mosi),
    .arm_cs(arm_cs),
    .arm_miso_o(arm_miso_o),
    .arm_miso_oe(arm_miso_oe),
    .main_sclk(main_sclk),
    .main_mosi(main_mosi),
    .main_cs(main_cs),
    .main_miso_o(main_miso_o),
    .main_miso_oe(main_miso_oe),
    .fire_permit_input(permit),
    .permit_filtered(permit_filtered),
    .high_side_switch(hs),
    .low_side_switch(ls),
    .firing_active(firing),
    .fire_success(success),
    .deploy_cmd_status(dep_status),
    .arm_timer_running(arm_run),
    .deploy_timer_running(dep_run)
  );

  sqad_host u_host (
    .mclk(mclk),
    .arm_sclk(arm_sclk),
    .arm_mosi(arm_mosi),
    .arm_cs(arm_cs),
    .arm_miso(arm_miso),
    .main_sclk(main_sclk),
    .main_mosi(main_mosi),
    .main_cs(main_cs),
    .main_miso(main_miso)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic set_permit(input logic v);
    permit <= v;
    cyc(20);
  endtask

  task automatic wait_off();
    for (int i = 0; i < 700 && hs !== 4'h0; i++) cyc(1);
    if (hs !== 4'h0) begin
      failures++;
      $display("mismatch at %0t: firing never ended", $time);
      finish_test();
    end
  endtask

  initial begin
    cyc(6);
    resetn <= 1'h1;
    cyc(1);
    check({hs, success, arm_run, dep_run}, 16'h0000, "outputs after reset");
    cyc(10);
    foreach (rows[k]) begin
      set_permit(rows[k].perm);
      if (rows[k].ord) begin
        u_host.send_main(rows[k].m, mr);
        u_host.send_arm(rows[k].a, ar);
      end else begin
        u_host.send_arm(rows[k].a, ar);
        u_host.send_main(rows[k].m, mr);
      end
      cyc(12);
      check(arm_run & ~rows[k].f, rows[k].a[3:0] & ~rows[k].f, "arm timers");
      check(dep_run & ~rows[k].f, (rows[k].perm ? rows[k].m[3:0] : 4'h0) & ~rows[k].f, "deploy timers");
      check(hs, rows[k].f, "switches");
      check(dep_status, rows[k].m[3:0], "deploy status");
      wait_off();
      check(success & rows[k].f, rows[k].f, "success");
      u_host.send_arm(8'h00, ar);
      u_host.send_main(16'h4000, mr);
      check({mr[15:13], mr[3:0]}, {3'h2, rows[k].m[3:0]}, "response");
      cyc(12);
      check({arm_run, dep_run}, 8'h00, "timers cleared");
    end
    // refresh and period end
    set_permit(1'h0);
    u_host.send_arm(8'h01, ar);
    cyc(300);
    u_host.send_arm(8'h01, ar);
    cyc(700);
    check(arm_run, 4'h1, "arm refresh");
    cyc(150);
    check(arm_run, 4'h0, "arm period end");
    // each source cancels only its own timer
    u_host.send_arm(8'h01, ar);
    u_host.send_main(16'h4000, mr);
    cyc(12);
    check(arm_run, 4'h1, "arm kept");
    set_permit(1'h1);
    u_host.send_main(16'h4002, mr);
    u_host.send_arm(8'h00, ar);
    cyc(12);
    check({hs, arm_run, dep_run}, 12'h002, "deploy kept");
    u_host.send_main(16'h4000, mr);
    cyc(12);
    check(dep_run, 4'h0, "deploy cancelled");
    // traffic while firing
    u_host.send_arm(8'h01, ar);
    u_host.send_main(16'h4001, mr);
    permit <= 1'h0;
    u_host.send_main(16'h0000, mr);
    u_host.send_arm(8'h02, ar);
    u_host.send_main(16'hC000, mr);
    check(mr, 16'hE000, "fault response");
    check(hs, 4'h1, "firing kept");
    check({ar, arm_run[1]}, 9'h022, "arming ignored");
    wait_off();
    u_host.send_arm(8'h00, ar);
    u_host.send_main(16'h4000, mr);
    // short permit pulse
    permit <= 1'h1;
    cyc(2);
    set_permit(1'h0);
    check(permit_filtered, 1'h0, "glitch ignored");
    set_permit(1'h1);
    check(permit_filtered, 1'h1, "permit high");
    // reset in mid firing
    u_host.send_arm(8'h01, ar);
    u_host.send_main(16'h4001, mr);
    cyc(20);
    check(hs, 4'h1, "firing on");
    resetn <= 1'h0;
    cyc(2);
    check({hs, ls, success}, 12'h000, "reset cuts firing");
    resetn <= 1'h1;
    cyc(6);
    finish_test();
  end
endmodule  // sqad_top_test
